// File: verilog/timer_start_bit_top.sv
// timer_start_bit_top: software watchdog timer with an AHB-Lite register slave and interrupt
// What this block does
// RULE1 - 15-bit counter counts up at oscillator/12 or oscillator/192.
// RULE2 - reload register bit 7 picks oscillator/12 or oscillator/192 prescaling.
// RULE3 - software sets the period only through the upper seven counter bits.
// RULE4 - start bit starts the counter; software can never stop it.
// RULE5 - overflow of the running counter forces an internal chip reset.
// RULE6 - refresh copies the reload register into the upper seven counter bits.
// RULE7 - refresh needs refresh bit write then start bit write, back to back.
// RULE8 - readable flag tells watchdog reset apart from external reset.
// RULE9 - counter holds its value during idle and power-down modes.
// RULE10 - shortest timeout is 256 us at 12 MHz, longer via reload/prescaler.
// RULE11 - refresh clears low byte; after any reset the watchdog stays stopped.
`timescale 1ns/1ps
module timer_start_bit_top #(
    parameter int DIV_FAST = timer_start_bit_pkg::DIV_FAST_RST,
    parameter int DIV_SLOW = timer_start_bit_pkg::DIV_SLOW_RST
)(
    input wire logic clock,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [timer_start_bit_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [timer_start_bit_pkg::BUS_W-1:0] hwdata,
    input wire logic hready,
    output logic [timer_start_bit_pkg::BUS_W-1:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic idle_mode,
    input wire logic power_down_mode,
    output logic wdt_reset,
    output logic irq
);
    import timer_start_bit_pkg::*;

    if (DIV_FAST < 2 || DIV_SLOW <= DIV_FAST)
    begin : g_bad_div
        $error("timer_start_bit_top: slow divider must exceed fast divider");
    end

    typedef struct packed {
        logic [7:0] reload;
        logic running;
        logic armed;
        logic cause;
        logic [IRQ_W-1:0] ist;
        logic [IRQ_W-1:0] imask;
        logic irq;
        logic dp_wr;
        logic [OFF_W-1:0] dp_addr;
        logic [BUS_W-1:0] rdata;
        logic reset_out;
    } timer_start_bit_top_state_t;

    localparam timer_start_bit_top_state_t TOP_RST = '{reload: RELOAD_RST, imask: IMASK_RST, default: '0};

    timer_start_bit_top_state_t s;
    timer_start_bit_top_state_t next_s;

    timer_start_bit_cnt_if cif();

    timer_start_bit_counter #(
        .DIV_FAST(DIV_FAST),
        .DIV_SLOW(DIV_SLOW)
    ) u_counter (
        .clock(clock),
        .rst(rst),
        .cif(cif)
    );

    logic accept;
    logic wr_ctrl;
    logic wr_trig;
    logic wr_start;
    logic refresh;
    logic [IRQ_W-1:0] events;
    logic [IRQ_W-1:0] ist_clr;

    function automatic logic [BUS_W-1:0] read_word(
        input logic [OFF_W-1:0] addr,
        input timer_start_bit_top_state_t st,
        input logic [CNT_W-1:0] count
    );
        logic [BUS_W-1:0] w;
        w = '0;
        case (addr)
            OFF_RELOAD: w[7:0] = st.reload;
            OFF_CTRL:
            begin
                w[CTRL_RUN_BIT] = st.running;
                w[CTRL_ARMED_BIT] = st.armed;
            end
            OFF_STAT: w[STAT_CAUSE_BIT] = st.cause; // see RULE8
            OFF_COUNT: w[CNT_W-1:0] = count;
            OFF_IST: w[IRQ_W-1:0] = st.ist;
            OFF_IMASK: w[IRQ_W-1:0] = st.imask;
            default: w = '0;
        endcase
        return w;
    endfunction

    always_comb
    begin
        accept = hsel && hready && htrans == HTRANS_NONSEQ;
        wr_ctrl = s.dp_wr && s.dp_addr == OFF_CTRL;
        wr_trig = wr_ctrl && hwdata[CTRL_TRIG_BIT];
        wr_start = wr_ctrl && hwdata[CTRL_START_BIT] && !hwdata[CTRL_TRIG_BIT];
        // only an armed start write refreshes; overflow beats a late refresh
        refresh = wr_start && s.armed && !cif.ovf; // see RULE7
        events = '0;
        events[IRQ_OVF_BIT] = cif.ovf;
        events[IRQ_REFRESH_BIT] = refresh;
        ist_clr = '0;

        next_s = s;
        next_s.dp_wr = accept && hwrite;
        next_s.dp_addr = haddr[OFF_W-1:0];
        next_s.reset_out = cif.ovf; // see RULE5

        // write data phase
        if (s.dp_wr)
        begin
            // any write other than the expected start write breaks the pair
            next_s.armed = 1'b0; // see RULE7
            case (s.dp_addr)
                OFF_RELOAD: next_s.reload = hwdata[7:0]; // see RULE3 see RULE2
                OFF_CTRL:
                begin
                    if (wr_trig)
                        next_s.armed = 1'b1; // see RULE7
                    else if (wr_start)
                        next_s.running = 1'b1; // see RULE4
                end
                OFF_IMASK: next_s.imask = hwdata[IRQ_W-1:0];
                default: next_s.reload = s.reload;
            endcase
        end

        // the watchdog's own reset returns it to the stopped state
        if (cif.ovf)
        begin
            next_s.running = 1'b0; // see RULE11 see RULE5
            next_s.armed = 1'b0;
            next_s.reload = RELOAD_RST;
            next_s.cause = 1'b1; // see RULE8
        end

        // read sees this cycle's writes; status clear is read-to-clear
        if (accept && !hwrite)
        begin
            next_s.rdata = read_word(haddr[OFF_W-1:0], next_s, cif.count);
            if (haddr[OFF_W-1:0] == OFF_IST)
                ist_clr = s.ist;
        end

        // a new event in the clearing cycle survives
        next_s.ist = (s.ist & ~ist_clr) | events;
        next_s.irq = |(next_s.ist & next_s.imask);
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            s <= TOP_RST; // see RULE11
        else
            s <= next_s;
    end

    assign cif.run = s.running;
    assign cif.halt = idle_mode || power_down_mode; // see RULE9
    assign cif.psel = s.reload[PSEL_BIT]; // see RULE2
    assign cif.reload = s.reload[RELOAD_W-1:0]; // see RULE6
    assign cif.load = refresh;

    assign hrdata = s.rdata;
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
    assign wdt_reset = s.reset_out;
    assign irq = s.irq;

    // helper for the period check: active cycles between steps
    logic [DIV_W:0] act;
    logic clean;
    logic psel_q;
    logic active;
    assign active = cif.run && !cif.halt;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            act <= '0;
            clean <= 1'b0;
            psel_q <= 1'b0;
        end
        else
        begin
            psel_q <= cif.psel;
            if (cif.tick)
            begin
                act <= {{DIV_W{1'b0}}, active};
                clean <= !cif.load;
            end
            else
            begin
                act <= (DIV_W+1)'(act + {{DIV_W{1'b0}}, active});
                clean <= clean && !cif.load && cif.psel == psel_q;
            end
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence seq_arm;
        wr_trig && !cif.ovf;
    endsequence

    sequence seq_fire;
        wr_start && !cif.ovf;
    endsequence

    sequence seq_wrap;
        cif.tick && cif.count == '0;
    endsequence

    property p_step;
        $changed(cif.count) && !$past(cif.load)
            |-> cif.count == CNT_W'($past(cif.count) + 1);
    endproperty

    property p_period;
        cif.tick && clean
            |-> act == ($past(cif.psel) ? (DIV_W+1)'(DIV_SLOW) : (DIV_W+1)'(DIV_FAST));
    endproperty

    property p_load;
        cif.load |=> cif.count == {$past(s.reload[RELOAD_W-1:0]), {LOW_W{1'b0}}};
    endproperty

    property p_refresh_pair;
        seq_arm ##1 seq_fire |-> cif.load;
    endproperty

    property p_overflow;
        seq_wrap |-> cif.ovf ##1 (wdt_reset && !s.running && s.cause) ##1 !wdt_reset;
    endproperty

    AST_STEP: assert property (p_step) // see RULE1 see RULE3
        else $error("counter moved by other than one step");
    AST_PERIOD: assert property (p_period) // see RULE2
        else $error("counter step spacing differs from prescaler");
    AST_LOAD: assert property (p_load) // see RULE6 see RULE11
        else $error("refresh did not load reload value over cleared low byte");
    AST_NO_STOP: assert property (s.running && !cif.ovf |=> s.running) // see RULE4
        else $error("running watchdog stopped without overflow");
    AST_START: assert property (seq_fire ##0 !s.running |=> s.running [*2]) // see RULE4
        else $error("start write did not start the counter");
    AST_OVERFLOW: assert property (p_overflow) // see RULE5
        else $error("overflow did not raise a one-cycle reset");
    AST_REFRESH_PAIR: assert property (p_refresh_pair) // see RULE7
        else $error("trigger then start did not refresh");
    AST_REFRESH_ONLY: assert property (p_refresh_only) // see RULE7
        else $error("refresh without the two-step sequence");
    AST_CAUSE_SET: assert property ($rose(s.cause) |-> $past(cif.ovf)) // see RULE8
        else $error("reset cause flag set without overflow");
    AST_CAUSE_HOLD: assert property (s.cause |=> s.cause) // see RULE8
        else $error("reset cause flag lost");
    AST_HALT: assert property (cif.halt && !cif.load |=> $stable(cif.count)) // see RULE9
        else $error("counter moved while halted");
    AST_IRQ: assert property (irq == |(s.ist & s.imask))
        else $error("interrupt output disagrees with status and mask");

    // a single-transfer master leaves an idle and an address cycle between two writes
    logic ist_rd;
    assign ist_rd = accept && !hwrite && haddr[OFF_W-1:0] == OFF_IST;

    sequence seq_quiet;
        !s.dp_wr && !cif.ovf;
    endsequence

    sequence seq_stat_read;
        accept && !hwrite && haddr[OFF_W-1:0] == OFF_STAT && !cif.ovf;
    endsequence

    sequence seq_reload_write;
        s.dp_wr && s.dp_addr == OFF_RELOAD && !cif.ovf;
    endsequence

    property p_refresh_only;
        cif.load |-> s.armed && s.dp_wr && s.dp_addr == OFF_CTRL
            && hwdata[CTRL_START_BIT] && !hwdata[CTRL_TRIG_BIT];
    endproperty

    property p_refresh_gap;
        seq_arm ##1 seq_quiet [*2] ##1 seq_fire |-> cif.load;
    endproperty

    property p_cause_read;
        seq_stat_read |=> hrdata == BUS_W'(s.cause);
    endproperty

    property p_reload_write;
        seq_reload_write |=> s.reload == $past(hwdata[7:0]);
    endproperty

    // only a refresh may touch the counter while it is not stepping
    property p_count_ro;
        s.dp_wr && s.dp_addr == OFF_COUNT && !cif.load && (!cif.run || cif.halt)
            |=> $stable(cif.count);
    endproperty

    property p_stopped;
        !s.running && !cif.load |=> $stable(cif.count);
    endproperty

    property p_ist_sticky;
        s.ist[IRQ_OVF_BIT] && !ist_rd |=> s.ist[IRQ_OVF_BIT];
    endproperty

    property p_ist_clear;
        ist_rd && events == '0 |=> s.ist == '0;
    endproperty

    AST_REFRESH_GAP: assert property (p_refresh_gap) // see RULE7
        else $error("trigger then start with idle cycles between did not refresh");
    AST_DISARM: assert property (s.dp_wr && s.dp_addr != OFF_CTRL |=> !s.armed) // see RULE7
        else $error("write between trigger and start left the refresh armed");
    AST_ARM: assert property (seq_arm |=> s.armed) // see RULE7
        else $error("trigger write did not arm the refresh");
    AST_START_DISARM: assert property (wr_start |=> !s.armed) // see RULE7
        else $error("start write left the refresh armed");
    AST_LOAD_ONCE: assert property (cif.load |=> !cif.load) // see RULE7
        else $error("one trigger gave two refreshes");
    AST_COUNT_RO: assert property (p_count_ro) // see RULE3
        else $error("count register write moved the counter");
    AST_RELOAD_WRITE: assert property (p_reload_write) // see RULE2 see RULE3
        else $error("reload write not stored");
    AST_LOW_CLEAR: assert property (cif.load |=> cif.count[LOW_W-1:0] == '0) // see RULE11
        else $error("refresh left low counter bits set");
    AST_STOPPED: assert property (p_stopped) // see RULE11
        else $error("stopped watchdog counter moved");
    AST_OVF_WRAP: assert property (cif.ovf |-> cif.tick && cif.count == '0) // see RULE5
        else $error("overflow without counter wrap");
    AST_RESET_SRC: assert property (wdt_reset |-> $past(cif.ovf)) // see RULE5
        else $error("chip reset request without overflow");
    AST_RESET_RELOAD: assert property (wdt_reset |-> s.reload == RELOAD_RST) // see RULE11
        else $error("watchdog reset did not restore the reload register");
    AST_TICK_HALT: assert property (cif.halt |=> !cif.tick) // see RULE9
        else $error("counter stepped while halted");
    AST_CAUSE_READ: assert property (p_cause_read) // see RULE8
        else $error("status read did not show the reset cause");
    AST_IST_OVF: assert property (cif.ovf |=> s.ist[IRQ_OVF_BIT])
        else $error("overflow did not set its status bit");
    AST_IST_REFRESH: assert property (cif.load |=> s.ist[IRQ_REFRESH_BIT])
        else $error("refresh did not set its status bit");
    AST_IST_STICKY: assert property (p_ist_sticky)
        else $error("overflow status bit lost before it was read");
    AST_IST_CLEAR: assert property (p_ist_clear)
        else $error("status read did not clear the status bits");
endmodule // timer_start_bit_top

// File: pkg/timer_start_bit_pkg.sv
// timer_start_bit_pkg: register map, field positions, reset values and timing for the watchdog
package timer_start_bit_pkg;
    // counter geometry
    localparam int CNT_W = 15;
    localparam int RELOAD_W = 7;
    localparam int LOW_W = 8;
    localparam int DIV_W = 8;
    localparam int IRQ_W = 2;
    localparam int BUS_W = 32;
    localparam int ADDR_W = 32;
    localparam int OFF_W = 8;

    // oscillator clocks per counter step (clock is the oscillator)
    localparam int DIV_FAST_RST = 12;
    localparam int DIV_SLOW_RST = 192;
    localparam int CLK_MHZ = 100;
    // shortest timeout: one pass through the low byte after a refresh
    localparam int MIN_TIMEOUT_TICKS = 2 ** LOW_W;
    localparam int MIN_TIMEOUT_CYCLES = MIN_TIMEOUT_TICKS * DIV_FAST_RST;

    // register byte offsets
    localparam logic [OFF_W-1:0] OFF_RELOAD = 8'h00;
    localparam logic [OFF_W-1:0] OFF_CTRL = 8'h04;
    localparam logic [OFF_W-1:0] OFF_STAT = 8'h08;
    localparam logic [OFF_W-1:0] OFF_COUNT = 8'h0C;
    localparam logic [OFF_W-1:0] OFF_IST = 8'h10;
    localparam logic [OFF_W-1:0] OFF_IMASK = 8'h14;

    // field positions
    localparam int PSEL_BIT = 7;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_TRIG_BIT = 1;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_ARMED_BIT = 1;
    localparam int STAT_CAUSE_BIT = 0;
    localparam int IRQ_OVF_BIT = 0;
    localparam int IRQ_REFRESH_BIT = 1;

    // reset values
    localparam logic [7:0] RELOAD_RST = 8'h00;
    localparam logic [IRQ_W-1:0] IMASK_RST = 2'h0;

    // bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;
endpackage

// File: pkg/timer_start_bit_cnt_if.sv
// timer_start_bit_cnt_if: control and status between the register side and the counter
`timescale 1ns/1ps
interface timer_start_bit_cnt_if;
    import timer_start_bit_pkg::*;
    logic run;
    logic halt;
    logic psel;
    logic load;
    logic [RELOAD_W-1:0] reload;
    logic [CNT_W-1:0] count;
    logic tick;
    logic ovf;
    modport ctl
    (
        output run, halt, psel, load, reload,
        input count, tick, ovf
    );
    modport cnt
    (
        input run, halt, psel, load, reload,
        output count, tick, ovf
    );
endinterface

// File: verilog/timer_start_bit_counter.sv
// timer_start_bit_counter: prescaler and 15-bit watchdog counter
`timescale 1ns/1ps
module timer_start_bit_counter #(
    parameter int DIV_FAST = timer_start_bit_pkg::DIV_FAST_RST,
    parameter int DIV_SLOW = timer_start_bit_pkg::DIV_SLOW_RST
)(
    input wire logic clock,
    input wire logic rst,
    timer_start_bit_cnt_if.cnt cif
);
    import timer_start_bit_pkg::*;

    if (DIV_FAST < 2 || DIV_SLOW < 2 || DIV_FAST > 2 ** DIV_W || DIV_SLOW > 2 ** DIV_W)
    begin : g_bad_div
        $error("timer_start_bit_counter: divider out of range");
    end

    localparam logic [DIV_W-1:0] LAST_FAST = DIV_W'(DIV_FAST - 1);
    localparam logic [DIV_W-1:0] LAST_SLOW = DIV_W'(DIV_SLOW - 1);

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic [CNT_W-1:0] count;
        logic tick;
        logic ovf;
    } timer_start_bit_cnt_state_t;

    timer_start_bit_cnt_state_t s;
    timer_start_bit_cnt_state_t next_s;
    logic [DIV_W-1:0] limit;

    always_comb
    begin
        next_s = s;
        next_s.tick = 1'b0;
        next_s.ovf = 1'b0;
        limit = cif.psel ? LAST_SLOW : LAST_FAST; // see RULE2
        if (cif.load)
        begin
            // low byte cleared so every refresh gives at least 256 steps
            next_s.count = {cif.reload, {LOW_W{1'b0}}}; // see RULE6 see RULE11 see RULE10
            next_s.div = '0;
        end
        else if (cif.run && !cif.halt) // see RULE9
        begin
            // >= keeps a psel change mid-period from skipping the wrap
            if (s.div >= limit)
            begin
                next_s.div = '0;
                next_s.count = CNT_W'(s.count + 1); // see RULE1
                next_s.tick = 1'b1;
                next_s.ovf = &s.count; // see RULE5
            end
            else
            begin
                next_s.div = DIV_W'(s.div + 1);
            end
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            s <= '0;
        else
            s <= next_s;
    end

    assign cif.count = s.count;
    assign cif.tick = s.tick;
    assign cif.ovf = s.ovf;
endmodule // timer_start_bit_counter

// File: verif/timer_start_bit_top_tb.sv
// timer_start_bit_top_tb: self-checking bench for the watchdog register slave and counter
`timescale 1ns/1ps
module timer_start_bit_top_tb;
    import timer_start_bit_pkg::*;
    // short dividers keep the fast timeout to about 500 cycles and the slow one to about a thousand
    localparam int DF = 2;
    localparam int DS = 4;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [ADDR_W-1:0] haddr = '0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic [BUS_W-1:0] hwdata = '0;
    logic idle_mode = 1'b0;
    logic power_down_mode = 1'b0;
    logic rd_ph = 1'b0;
    logic [BUS_W-1:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic wdt_reset;
    logic irq;
    logic [BUS_W-1:0] r;
    logic [BUS_W-1:0] exp_q[$];
    string nm_q[$];
    int to_q[$];
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int t0 = 0;
    int w;

    timer_start_bit_top #(.DIV_FAST(DF), .DIV_SLOW(DS)) u_dut (
        .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .idle_mode(idle_mode), .power_down_mode(power_down_mode),
        .wdt_reset(wdt_reset), .irq(irq)
    );

    initial
    begin
        forever #5 clock = ~clock;
    end

    task automatic check(input string n, input logic [BUS_W-1:0] seen,
                         input logic [BUS_W-1:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic test_done;
        if (fail_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // one single transfer; a read notes its expected word for the monitor
    task automatic bus(input logic [7:0] a, input logic wr_en, input logic [BUS_W-1:0] d,
                       input string n);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr_en;
        hsize <= 3'h2;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        if (!wr_en)
        begin
            exp_q.push_back(d);
            nm_q.push_back(n);
        end
        rd_ph <= !wr_en;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd_ph <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [BUS_W-1:0] d);
        bus(a, 1'b1, d, "");
    endtask

    task automatic rd(input logic [7:0] a, input logic [BUS_W-1:0] e, input string n);
        bus(a, 1'b0, e, n);
    endtask

    // ceiling well above the two timeouts plus register traffic
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fail_count++;
            test_done();
        end
    end

    always @(posedge clock)
    begin
        if (hsel === 1'b1)
            check("hreadyout", 32'(hreadyout), 32'h1);
        if (rd_ph && hreadyout === 1'b1 && exp_q.size() > 0)
        begin
            check(nm_q.pop_front(), hrdata, exp_q.pop_front());
            check("hresp", 32'(hresp), 32'(HRESP_OKAY));
        end
        if (wdt_reset === 1'b1)
        begin
            w = (to_q.size() > 0) ? to_q.pop_front() : -100;
            // two cycles of slack for prescaler phase at start
            check("timeout", 32'((cyc - t0 - w) inside {[-2:2]}), 32'h1);
        end
    end

    initial
    begin
        void'($urandom(32'h018859E4));
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        rd(OFF_RELOAD, 32'(RELOAD_RST), "reload");
        rd(OFF_CTRL, 32'h0, "ctrl");
        rd(OFF_STAT, 32'h0, "cause");
        rd(OFF_COUNT, 32'h0, "count");
        rd(OFF_IMASK, 32'(IMASK_RST), "imask");
        rd(8'h18, 32'h0, "unmapped");
        wr(OFF_COUNT, 32'h7FFF);
        rd(OFF_COUNT, 32'h0, "count_ro");
        idle_mode <= 1'b1;
        wr(OFF_IMASK, 32'h1);
        rd(OFF_IMASK, 32'h1, "imask");
        for (int i = 0; i < 4; i++)
        begin
            r = $urandom;
            r = {24'h0, r[7:0]};
            wr(OFF_RELOAD, r);
            rd(OFF_RELOAD, r, "reload");
            wr(OFF_CTRL, 32'h2);
            rd(OFF_CTRL, (i == 0) ? 32'h2 : 32'h3, "armed");
            wr(OFF_CTRL, 32'h1);
            rd(OFF_COUNT, {17'h0, r[6:0], 8'h00}, "refresh");
            rd(OFF_CTRL, 32'h1, "running");
        end
        rd(OFF_IST, 32'h2, "ist");
        // a write between the two steps must cancel the refresh
        wr(OFF_CTRL, 32'h2);
        wr(OFF_RELOAD, 32'h7F);
        wr(OFF_CTRL, 32'h1);
        rd(OFF_COUNT, {17'h0, r[6:0], 8'h00}, "no_refresh");
        rd(OFF_IST, 32'h0, "ist");
        wr(OFF_CTRL, 32'h0);
        rd(OFF_CTRL, 32'h1, "no_stop");
        idle_mode <= 1'b0;
        power_down_mode <= 1'b1;
        repeat (30) @(posedge clock);
        rd(OFF_COUNT, {17'h0, r[6:0], 8'h00}, "frozen");
        wr(OFF_CTRL, 32'h2);
        wr(OFF_CTRL, 32'h1);
        rd(OFF_COUNT, 32'h7F00, "refresh");
        t0 = cyc;
        to_q.push_back(256 * DF + 2);
        power_down_mode <= 1'b0;
        while (to_q.size() > 0) @(posedge clock);
        check("irq", 32'(irq), 32'h1);
        rd(OFF_STAT, 32'h1, "cause");
        rd(OFF_CTRL, 32'h0, "stopped");
        rd(OFF_RELOAD, 32'h0, "reload");
        rd(OFF_IST, 32'h3, "ist");
        check("irq", 32'(irq), 32'h0);
        // stopped watchdog: armed start both starts and refreshes
        wr(OFF_RELOAD, 32'hFF);
        wr(OFF_CTRL, 32'h2);
        wr(OFF_CTRL, 32'h1);
        t0 = cyc;
        to_q.push_back(256 * DS + 2);
        while (to_q.size() > 0) @(posedge clock);
        rd(OFF_STAT, 32'h1, "cause");
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd(OFF_STAT, 32'h0, "cause_ext");
        rd(OFF_CTRL, 32'h0, "stopped");
        test_done();
    end
endmodule // timer_start_bit_top_tb
